/* File: hdl/agr_pkg.sv */
// Constants for the address-gate and CPU reset speed-up block.
// Assumes a 200 MHz host-interface clock.
package agr_pkg;
  localparam logic [7:0] CFG_INDEX       = 8'hF0;
  localparam logic [7:0] CFG_RESET_VAL   = 8'h00;
  localparam logic [7:0] CFG_USED_MASK   = 8'h07;
  localparam int         CFG_FASTPORT_BIT = 2;
  localparam int         CFG_GATE_BIT    = 1;
  localparam int         CFG_RESET_BIT   = 0;
  localparam logic [7:0] CMD_SET_GATE    = 8'hD1;
  localparam logic [7:0] CMD_PULSE_RESET = 8'hFE;
  localparam logic [7:0] CMD_NULL        = 8'hFF;
  localparam int         DATA_GATE_BIT   = 1;
  localparam int         DATA_RESET_BIT  = 0;
  localparam int         CLK_MHZ         = 200;
  localparam int         RST_DELAY_US    = 14;
  localparam int         RST_WIDTH_US    = 6;
  // Least times: exact multiples, so no rounding needed
  localparam int         RST_DELAY_CYC   = RST_DELAY_US * CLK_MHZ;
  localparam int         RST_WIDTH_CYC   = RST_WIDTH_US * CLK_MHZ;
  localparam int         CNT_W           = 13;

  typedef enum logic [1:0]
  {
    PUL_IDLE  = 2'b00,
    PUL_DELAY = 2'b01,
    PUL_LOW   = 2'b10
  } agr_pul_state_t;
endpackage : agr_pkg

/* File: hdl/agr_pulse_gen.sv */
// Timed CPU reset pulse: waits, then drives low for a fixed width.
// Assumes a one-cycle start strobe on the same clock.
`timescale 1ns/1ps
module agr_pulse_gen
  import agr_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  output logic      o_pulse_n,
  output logic      o_busy
);
  typedef struct packed
  {
    agr_pul_state_t   st;
    logic [CNT_W-1:0] cnt;
    logic             out_n;
  } agr_pul_t;

  agr_pul_t s_reg;
  agr_pul_t s_next;

  always_comb
  begin
    s_next = s_reg;
    unique case (s_reg.st)
      PUL_IDLE:
      begin
        if (i_start)
        begin
          s_next.st  = PUL_DELAY;
          s_next.cnt = CNT_W'(RST_DELAY_CYC - 1);
        end
      end
      PUL_DELAY:
      begin
        if (s_reg.cnt == '0)
        begin
          s_next.st    = PUL_LOW;
          s_next.cnt   = CNT_W'(RST_WIDTH_CYC - 1);
          s_next.out_n = 1'b0;
        end
        else
          s_next.cnt = s_reg.cnt - 1'b1;
      end
      PUL_LOW:
      begin
        if (s_reg.cnt == '0)
        begin
          s_next.st    = PUL_IDLE;
          s_next.out_n = 1'b1;
        end
        else
          s_next.cnt = s_reg.cnt - 1'b1;
      end
      default:
      begin
        s_next.st    = PUL_IDLE;
        s_next.out_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      s_reg <= '{st: PUL_IDLE, cnt: '0, out_n: 1'b1};
    else
      s_reg <= s_next;
  end

  assign o_pulse_n = s_reg.out_n;
  assign o_busy    = (s_reg.st != PUL_IDLE);
endmodule : agr_pulse_gen

/* File: hdl/agr_speedup.sv */
// Address-gate and CPU reset speed-up: watches host command/data writes.
// Assumes host write strobe, select and data are synchronous one-cycle
// inputs from the host interface; pins external are resolved by the bench.
//
// Function
// - Config bit 2 enables merging with the fast control port.
// - Gate comes from firmware or hardware by config bit 1.
// - Reset comes from firmware or hardware by config bit 0.
// - Fast port enabled: merge chosen gate and reset with its outputs.
// - After D1 command, data bit 1 goes to the gate latch.
// - Same transaction copies data bit 0 into the reset latch.
// - With hardware gate selected, set-gate transaction never raises output-full or input-full flags.
// - Select high means command, low means data; data uses bits 1 and 0.
// - Gate holds on command, repeated D1, and trailing FF writes.
// - D1 then other command or extra data: flag input full, idle.
// - FE command with hardware reset selected pulses reset, no flag.
// - Reset pulse starts after 14 us, low at least 6 us.
// - After power-on reset, gate and reset outputs stay undriven.
// - Output polarity of gate and reset follows the polarity bit.
// - Firmware reset mode: controller firmware makes the FE pulse.
// - Reset is ANDed active low with the alternate reset pulse.
// - Gate is ORed with the alternate gate bit.
`timescale 1ns/1ps
module agr_speedup
  import agr_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_host_wr,
  input  wire logic       i_command_data_select,
  input  wire logic [7:0] i_host_data,
  input  wire logic       i_cfg_wr,
  input  wire logic [7:0] i_cfg_index,
  input  wire logic [7:0] i_cfg_wdata,
  output logic      [7:0] o_cfg_rdata,
  input  wire logic       i_controller_gate_signal,
  input  wire logic       i_controller_reset_n,
  input  wire logic       i_alternate_gate_bit,
  input  wire logic       i_alternate_reset_pulse_n,
  input  wire logic       i_gpio_polarity,
  output logic            o_addr20_gate_out,
  output logic            o_addr20_gate_oe,
  output logic            o_cpu_reset_pulse,
  output logic            o_cpu_reset_oe,
  output logic            o_host_output_full_signal,
  output logic            o_input_buffer_full_flag,
  output logic            o_fw_write
);
  typedef struct packed
  {
    logic [7:0] cfg;
    logic       pending;
    logic       gate;
    logic       rst_latch;
    logic       input_buffer_full_flag;
    logic       obf;
    logic       fw_write;
    logic       drive_en;
    logic       gate_out;
    logic       rst_out;
  } agr_state_t;

  agr_state_t s_reg;
  agr_state_t s_next;
  logic       pulse_start;
  logic       pulse_n;
  logic       is_cmd;
  logic       hw_gate;
  logic       hw_rst;
  logic       fast_en;
  logic       gate_sel;
  logic       rst_sel_n;

  assign is_cmd  = i_command_data_select;
  assign fast_en = s_reg.cfg[CFG_FASTPORT_BIT];
  assign hw_gate = s_reg.cfg[CFG_GATE_BIT];
  assign hw_rst  = s_reg.cfg[CFG_RESET_BIT];

  agr_pulse_gen u_pulse
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_start   (pulse_start),
    .o_pulse_n (pulse_n),
    .o_busy    ()
  );

  always_comb
  begin
    s_next          = s_reg;
    pulse_start     = 1'b0;
    s_next.fw_write = 1'b0;
    s_next.obf      = 1'b0;
    if (i_cfg_wr && i_cfg_index == CFG_INDEX)
    begin
      s_next.cfg      = i_cfg_wdata & CFG_USED_MASK;
      s_next.drive_en = 1'b1;
    end
    if (i_host_wr)
    begin
      if (is_cmd)
      begin
        if (hw_gate && i_host_data == CMD_SET_GATE)
          s_next.pending = 1'b1;
        else if (hw_gate && i_host_data == CMD_NULL && !s_reg.pending
                 && !s_reg.input_buffer_full_flag)
          s_next.pending = 1'b0;
        else if (hw_rst && i_host_data == CMD_PULSE_RESET
                 && !s_reg.pending)
          pulse_start = 1'b1;
        else
        begin
          s_next.pending  = 1'b0;
          s_next.input_buffer_full_flag      = 1'b1;
          s_next.fw_write = 1'b1;
          s_next.obf      = 1'b1;
        end
      end
      else if (hw_gate && s_reg.pending)
      begin
        s_next.gate      = i_host_data[DATA_GATE_BIT];
        s_next.rst_latch = i_host_data[DATA_RESET_BIT];
        s_next.pending   = 1'b0;
      end
      else
      begin
        s_next.input_buffer_full_flag      = 1'b1;
        s_next.fw_write = 1'b1;
        s_next.obf      = 1'b1;
      end
    end
    else if (!s_reg.pending && s_reg.input_buffer_full_flag && !i_host_wr)
      s_next.input_buffer_full_flag = 1'b0;
    gate_sel = hw_gate ? s_reg.gate : i_controller_gate_signal;
    if (fast_en)
      gate_sel = gate_sel | i_alternate_gate_bit;
    rst_sel_n = hw_rst ? pulse_n : i_controller_reset_n;
    if (fast_en)
      rst_sel_n = rst_sel_n & i_alternate_reset_pulse_n;
    s_next.gate_out = gate_sel ^ i_gpio_polarity;
    s_next.rst_out  = rst_sel_n ^ i_gpio_polarity;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      s_reg <= '{cfg: CFG_RESET_VAL, rst_out: 1'b1, default: 1'b0};
    else
      s_reg <= s_next;
  end

  assign o_cfg_rdata = (i_cfg_index == CFG_INDEX) ? s_reg.cfg : 8'h00;
  assign o_addr20_gate_out = s_reg.gate_out;
  assign o_cpu_reset_pulse = s_reg.rst_out;
  assign o_addr20_gate_oe  = s_reg.drive_en;
  assign o_cpu_reset_oe    = s_reg.drive_en;
  assign o_host_output_full_signal = s_reg.obf;
  assign o_input_buffer_full_flag  = s_reg.input_buffer_full_flag;
  assign o_fw_write = s_reg.fw_write;
endmodule : agr_speedup

/* File: tb/agr_host_model.sv */
// Host writer for keyboard command and data ports.
// Assumes a write is taken at the edge after it is driven.
`timescale 1ns/1ps
module agr_host_model
(
  input  wire logic       i_sys_clk,
  output logic            o_host_wr = 1'b0,
  output logic            o_select  = 1'b0,
  output logic      [7:0] o_data    = 8'h00
);
  task automatic put(input logic sel, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_host_wr <= 1'b1;
    o_select  <= sel;
    o_data    <= d;
    @(posedge i_sys_clk);
    // Idle bus inverted, never stale
    o_host_wr <= 1'b0;
    o_data    <= ~d;
  endtask : put
endmodule : agr_host_model

/* File: tb/agr_speedup_checker.sv */
// Checker on agr_speedup ports.
// Assumes config starts at zero.
`timescale 1ns/1ps
module agr_speedup_checker
  import agr_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_host_wr,
  input wire logic       i_command_data_select,
  input wire logic [7:0] i_host_data,
  input wire logic       i_cfg_wr,
  input wire logic [7:0] i_cfg_index,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic       i_controller_gate_signal,
  input wire logic       i_controller_reset_n,
  input wire logic       i_alternate_gate_bit,
  input wire logic       i_alternate_reset_pulse_n,
  input wire logic       i_gpio_polarity,
  input wire logic       o_addr20_gate_out,
  input wire logic       o_addr20_gate_oe,
  input wire logic       o_cpu_reset_pulse,
  input wire logic       o_input_buffer_full_flag,
  input wire logic       o_host_output_full_signal
);
  logic [2:0]  cfg_reg;
  logic        seen_reg, pend_reg, cmd_w, fe_go, hide, fw_g, fw_r;
  logic [12:0] cnt_reg;
  assign cmd_w = i_host_wr && i_command_data_select;
  assign fe_go = cmd_w && i_host_data == CMD_PULSE_RESET && cfg_reg[0]
                 && !pend_reg;
  assign hide  = (cmd_w && i_host_data == CMD_SET_GATE && cfg_reg[1])
                 || (pend_reg && i_host_wr && !i_command_data_select);
  assign fw_g  = (i_controller_gate_signal
                 | (cfg_reg[2] & i_alternate_gate_bit)) ^ i_gpio_polarity;
  assign fw_r  = (i_controller_reset_n
                 & (!cfg_reg[2] | i_alternate_reset_pulse_n)) ^ i_gpio_polarity;
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      {cfg_reg, seen_reg, pend_reg, cnt_reg} <= '0;
    else
    begin
      if (i_cfg_wr && i_cfg_index == CFG_INDEX)
        {cfg_reg, seen_reg} <= {i_cfg_wdata[2:0], 1'b1};
      if (i_host_wr)
        pend_reg <= cmd_w && i_host_data == CMD_SET_GATE && cfg_reg[1];
      // Saturates past the pulse end
      if (fe_go || (cnt_reg != 13'h0 && cnt_reg < 13'h1004))
        cnt_reg <= fe_go ? 13'h1 : cnt_reg + 13'h1;
    end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_OE_POR: assert property (!seen_reg |-> !o_addr20_gate_oe)
    else $error("gate driven early");
  AST_HIDE: assert property ((hide || fe_go) |=> !o_input_buffer_full_flag)
    else $error("hidden write flagged");
  AST_BAD: assert property ((pend_reg && cmd_w && i_host_data != CMD_SET_GATE)
    |=> o_input_buffer_full_flag && o_host_output_full_signal) else $error("bad seq");
  AST_GATE_HW: assert property ((pend_reg && i_host_wr && !i_command_data_select
    && !cfg_reg[2]) |-> ##2 o_addr20_gate_out == ($past(i_host_data[1], 2)
    ^ i_gpio_polarity)) else $error("gate latch");
  AST_GATE_FW: assert property ((seen_reg && !cfg_reg[1])
    |=> o_addr20_gate_out == $past(fw_g)) else $error("fw gate");
  AST_RST_FW: assert property (!cfg_reg[0] |=> o_cpu_reset_pulse == $past(fw_r))
    else $error("fw reset");
  AST_PUL_WAIT: assert property ((cnt_reg > 13'h0 && cnt_reg < 13'hAEB)
    |=> o_cpu_reset_pulse != i_gpio_polarity) else $error("pulse early");
  AST_PUL_LOW: assert property ((cnt_reg > 13'hAF5 && cnt_reg < 13'hF9B)
    |-> o_cpu_reset_pulse == i_gpio_polarity) else $error("pulse short");
endmodule : agr_speedup_checker
bind agr_speedup agr_speedup_checker agr_speedup_checker_inst (.*);

/* File: tb/testbench.sv */
// Bench for agr_speedup with a behavioural model.
// Assumes checker bound in its own file.
`timescale 1ns/1ps
module testbench;
  import agr_pkg::*;
  logic       clk, rst, cfg_wr, cg, cr_n, ag, ar_n, pol, wr, sel;
  logic       gate, g_oe, rpul, r_oe, input_buffer_full_flag, obf, fww;
  logic [7:0] idx, wd, rd, dat, v;
  int         n_errors, num_checks, cfg, latch, n;
  agr_host_model agr_host_model_inst (.i_sys_clk(clk), .o_host_wr(wr),
    .o_select(sel), .o_data(dat));
  agr_speedup agr_speedup_inst (.i_sys_clk(clk), .i_rst(rst), .i_host_wr(wr),
    .i_command_data_select(sel), .i_host_data(dat), .i_cfg_wr(cfg_wr),
    .i_cfg_index(idx), .i_cfg_wdata(wd), .o_cfg_rdata(rd),
    .i_controller_gate_signal(cg), .i_controller_reset_n(cr_n),
    .i_alternate_gate_bit(ag), .i_alternate_reset_pulse_n(ar_n),
    .i_gpio_polarity(pol), .o_addr20_gate_out(gate), .o_addr20_gate_oe(g_oe),
    .o_cpu_reset_pulse(rpul), .o_cpu_reset_oe(r_oe), .o_fw_write(fww),
    .o_host_output_full_signal(obf), .o_input_buffer_full_flag(input_buffer_full_flag));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hw(input logic s, input logic [7:0] d);
    agr_host_model_inst.put(s, d);
  endtask : hw
  task automatic cfg_put(input logic [7:0] i, input logic [7:0] w);
    @(posedge clk);
    {cfg_wr, idx, wd} <= {1'b1, i, w};
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg = (i == CFG_INDEX) ? int'(w & CFG_USED_MASK) : cfg;
  endtask : cfg_put
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
    chk(gate, ((cfg[1] ? latch[0] : cg) | (cfg[2] & ag)) ^ pol);
    chk(rpul, ((cfg[0] | cr_n) & (!cfg[2] | ar_n)) ^ pol);
    chk({rd, g_oe, r_oe}, {((idx == CFG_INDEX) ? 8'(cfg) : 8'h00), 2'b11});
  endtask : settle
  task automatic span(input logic lvl);
    n = 0;
    while (rpul === lvl && n < 5000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : span
  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    {rst, cfg_wr, cg, cr_n, ag, ar_n, pol, idx, wd} = {7'b1001010, 16'h0};
    void'($urandom(94233));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({g_oe, r_oe}, 8'h00);
    repeat (24)
    begin
      cfg_put(CFG_INDEX, 8'($urandom));
      {cg, cr_n, ag, ar_n, pol, v} <= 13'($urandom);
      hw(1'b1, CMD_SET_GATE);
      if (v[7])
        hw(1'b1, CMD_SET_GATE);
      hw(1'b0, v);
      latch = cfg[1] ? v[1] : latch;
      hw(1'b1, CMD_NULL);
      settle();
    end
    cfg_put(8'hF1, 8'h55);
    settle();
    cfg_put(CFG_INDEX, 8'h03);
    hw(1'b1, CMD_SET_GATE);
    hw(1'b1, 8'($urandom_range(8'hD0)));
    #1;
    chk({input_buffer_full_flag, obf, fww}, 3'b111);
    settle();
    {ar_n, pol} <= 2'b10;
    hw(1'b1, CMD_PULSE_RESET);
    #1;
    chk({input_buffer_full_flag, obf, fww}, 3'b000);
    span(1'b1);
    chk(n >= RST_DELAY_CYC && n <= RST_DELAY_CYC + 2, 8'h01);
    span(1'b0);
    chk(n >= RST_WIDTH_CYC && n <= RST_WIDTH_CYC + 2, 8'h01);
    wrap_up();
  end
endmodule : testbench
